// [design/sev_regs.sv]
`timescale 1ns/1ps
module sev_regs
  import sev_pkg::*;
#(
  parameter logic FIRST_REVISION = 1'b0
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_supply_glitch,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic [7:0]      o_reg_rdata,
  input  wire sev_light_s i_light,
  input  wire sev_near_s  i_near,
  input  wire sev_gain_s  i_factory_gain,
  output logic            o_event_n_out,
  output logic            o_event_n_oe,
  output sev_gain_s       o_gain,
  output logic            o_analog_on,
  output sev_light_src_e  o_light_src,
  output logic            o_light_run,
  output logic            o_near_run
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0]  event_status;
  logic [7:0]  main_control;
  logic [13:0] upper_threshold;
  logic [13:0] lower_threshold;
  logic [7:0]  persist_counts;
  logic [7:0]  near_threshold_indicator;
  logic [7:0]  near_threshold_level;
  logic [7:0]  green_gain_with_ir_lsb;
  logic [7:0]  infrared_gain_upper;
  logic [2:0]  light_run_count;
  logic [2:0]  near_run_count;
  logic        glitch_meta;
  logic        glitch_sync;
  logic        glitch_seen;

  // ----------------------------------------------------------------
  // Supply glitch synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      glitch_meta <= 1'b0;
      glitch_sync <= 1'b0;
      glitch_seen <= 1'b0;
    end else begin
      glitch_meta <= i_supply_glitch;
      glitch_sync <= glitch_meta;
      glitch_seen <= glitch_sync;
    end
  end

  wire glitch_rise = glitch_sync & ~glitch_seen;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_control  = i_reg_wr && (i_reg_addr == SEV_OFS_CONTROL);
  wire wr_up_hi    = i_reg_wr && (i_reg_addr == SEV_OFS_UP_HI);
  wire wr_up_lo    = i_reg_wr && (i_reg_addr == SEV_OFS_UP_LO);
  wire wr_dn_hi    = i_reg_wr && (i_reg_addr == SEV_OFS_DN_HI);
  wire wr_dn_lo    = i_reg_wr && (i_reg_addr == SEV_OFS_DN_LO);
  wire wr_persist  = i_reg_wr && (i_reg_addr == SEV_OFS_PERSIST);
  wire wr_near_ind = i_reg_wr && (i_reg_addr == SEV_OFS_NEAR_IND);
  wire wr_near_thr = i_reg_wr && (i_reg_addr == SEV_OFS_NEAR_THR);
  wire wr_green_gn = i_reg_wr && (i_reg_addr == SEV_OFS_GREEN_GN);
  wire wr_ir_gn    = i_reg_wr && (i_reg_addr == SEV_OFS_IR_GN);
  wire rd_status   = i_reg_rd && (i_reg_addr == SEV_OFS_STATUS);

  wire [2:0] mode       = main_control[SEV_MSB_MODE:SEV_LSB_MODE];
  wire       light_en   = main_control[SEV_BIT_LIGHT_EN];
  wire       near_en    = main_control[SEV_BIT_NEAR_EN];
  wire       gain_src   = main_control[SEV_BIT_GAIN_SRC];
  wire [1:0] light_pst  = persist_counts[SEV_LSB_LIGHT_PST +: 2];
  wire [1:0] near_pst   = persist_counts[SEV_LSB_NEAR_PST +: 2];

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Reserved codes behave as shutdown so the analog side stays idle.
  wire light_mode = (mode == SEV_MODE_G_MINUS_IR) ||
                    (mode == SEV_MODE_GREEN) ||
                    (mode == SEV_MODE_INFRARED) ||
                    (mode == SEV_MODE_ALTERNATE);
  wire near_mode  = (mode == SEV_MODE_ALTERNATE) ||
                    (mode == SEV_MODE_NEAR_ONLY);

  assign o_light_run = light_mode;
  assign o_near_run  = near_mode;
  assign o_analog_on = light_mode | near_mode;

  always_comb begin
    case (mode)
      SEV_MODE_G_MINUS_IR: o_light_src = SEV_SRC_G_MINUS_IR;
      SEV_MODE_GREEN:      o_light_src = SEV_SRC_GREEN;
      SEV_MODE_INFRARED:   o_light_src = SEV_SRC_INFRARED;
      SEV_MODE_ALTERNATE:  o_light_src = SEV_SRC_G_MINUS_IR;
      default:             o_light_src = SEV_SRC_NONE;
    endcase
  end

  // ----------------------------------------------------------------
  // Gain selection
  // ----------------------------------------------------------------
  wire sev_gain_s soft_gain = '{
    green:    green_gain_with_ir_lsb[7:1],
    infrared: {infrared_gain_upper, green_gain_with_ir_lsb[0]}
  };

  assign o_gain = gain_src ? i_factory_gain : soft_gain;

  // ----------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------
  // Readings only count when the matching measurement is running.
  wire light_take = i_light.valid && light_mode && light_en;
  wire near_take  = i_near.valid && near_mode && near_en;

  wire light_out  = (i_light.value > upper_threshold) ||
                    (i_light.value < lower_threshold);
  wire near_above = i_near.value > near_threshold_level;

  wire [2:0] light_run_next = (light_run_count == 3'h7) ?
                              light_run_count : light_run_count + 3'h1;
  wire [2:0] near_run_next  = (near_run_count == 3'h7) ?
                              near_run_count : near_run_count + 3'h1;

  wire light_hit = light_take && light_out &&
                   (light_run_next > {1'b0, light_pst});
  wire light_ovf = light_take && i_light.overflow;
  wire near_hit  = near_take && near_above &&
                   (near_run_next > {1'b0, near_pst});

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      light_run_count <= 3'h0;
      near_run_count  <= 3'h0;
    end else begin
      if (!light_en || glitch_rise) begin
        light_run_count <= 3'h0;
      end else if (light_take) begin
        light_run_count <= light_out ? light_run_next : 3'h0;
      end
      if (!near_en || glitch_rise) begin
        near_run_count <= 3'h0;
      end else if (near_take) begin
        near_run_count <= near_above ? near_run_next : 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  // A new event wins over a clearing read in the same cycle.
  wire next_light_en = wr_control ? i_reg_wdata[SEV_BIT_LIGHT_EN]
                                  : light_en;
  wire next_near_en  = wr_control ? i_reg_wdata[SEV_BIT_NEAR_EN]
                                  : near_en;

  wire next_light_flag = next_light_en &&
    (light_hit || light_ovf ||
     (event_status[SEV_BIT_LIGHT_FLAG] && !rd_status));
  wire next_near_flag  = next_near_en &&
    (near_hit ||
     (event_status[SEV_BIT_NEAR_FLAG] && !rd_status));
  wire next_power_flag = glitch_rise ||
    (event_status[SEV_BIT_POWER_FLAG] && !rd_status);

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      event_status <= SEV_RST_STATUS[2:0];
    end else begin
      event_status <= {next_power_flag, next_near_flag,
                       next_light_flag};
    end
  end

  // ----------------------------------------------------------------
  // Event request line
  // ----------------------------------------------------------------
  wire power_drives = event_status[SEV_BIT_POWER_FLAG] &&
                      !FIRST_REVISION;

  assign o_event_n_out = 1'b0;
  assign o_event_n_oe  = event_status[SEV_BIT_LIGHT_FLAG] ||
                         event_status[SEV_BIT_NEAR_FLAG] ||
                         power_drives;

  // ----------------------------------------------------------------
  // Control and threshold registers
  // ----------------------------------------------------------------
  // Only writes change main_control; a supply glitch also reloads the thresholds and persist_counts. Shutdown leaves them intact.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      main_control <= SEV_RST_CONTROL;
    end else if (wr_control) begin
      main_control <= {2'b00, i_reg_wdata[5:0]};
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      upper_threshold          <= {SEV_RST_THRESH[5:0], SEV_RST_THRESH};
      lower_threshold          <= {SEV_RST_THRESH[5:0], SEV_RST_THRESH};
      persist_counts           <= SEV_RST_PERSIST;
      near_threshold_indicator <= SEV_RST_THRESH;
      near_threshold_level     <= SEV_RST_THRESH;
    end else if (glitch_rise) begin
      upper_threshold          <= {SEV_RST_THRESH[5:0], SEV_RST_THRESH};
      lower_threshold          <= {SEV_RST_THRESH[5:0], SEV_RST_THRESH};
      persist_counts           <= SEV_RST_PERSIST;
      near_threshold_indicator <= SEV_RST_THRESH;
      near_threshold_level     <= SEV_RST_THRESH;
    end else begin
      if (wr_up_hi) begin
        upper_threshold[13:8] <= i_reg_wdata[5:0];
      end
      if (wr_up_lo) begin
        upper_threshold[7:0] <= i_reg_wdata;
      end
      if (wr_dn_hi) begin
        lower_threshold[13:8] <= i_reg_wdata[5:0];
      end
      if (wr_dn_lo) begin
        lower_threshold[7:0] <= i_reg_wdata;
      end
      if (wr_persist) begin
        persist_counts <= {4'h0, i_reg_wdata[3:0]};
      end
      if (wr_near_ind) begin
        near_threshold_indicator <= i_reg_wdata;
      end
      if (wr_near_thr) begin
        near_threshold_level <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      green_gain_with_ir_lsb <= SEV_RST_GAIN;
      infrared_gain_upper    <= SEV_RST_GAIN;
    end else begin
      if (wr_green_gn) begin
        green_gain_with_ir_lsb <= i_reg_wdata;
      end
      if (wr_ir_gn) begin
        infrared_gain_upper <= i_reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] read_mux;

  always_comb begin
    case (i_reg_addr)
      SEV_OFS_STATUS:   read_mux = {5'h00, event_status};
      SEV_OFS_CONTROL:  read_mux = main_control;
      SEV_OFS_UP_HI:    read_mux = {2'b00, upper_threshold[13:8]};
      SEV_OFS_UP_LO:    read_mux = upper_threshold[7:0];
      SEV_OFS_DN_HI:    read_mux = {2'b00, lower_threshold[13:8]};
      SEV_OFS_DN_LO:    read_mux = lower_threshold[7:0];
      SEV_OFS_PERSIST:  read_mux = persist_counts;
      SEV_OFS_NEAR_IND: read_mux = near_threshold_indicator;
      SEV_OFS_NEAR_THR: read_mux = near_threshold_level;
      SEV_OFS_GREEN_GN: read_mux = green_gain_with_ir_lsb;
      SEV_OFS_IR_GN:    read_mux = infrared_gain_upper;
      default:          read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= read_mux;
    end
  end

endmodule : sev_regs

// [design/sev_pkg.sv]
package sev_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SEV_OFS_STATUS    = 8'h00;
  localparam logic [7:0] SEV_OFS_CONTROL   = 8'h01;
  localparam logic [7:0] SEV_OFS_UP_HI     = 8'h06;
  localparam logic [7:0] SEV_OFS_UP_LO     = 8'h07;
  localparam logic [7:0] SEV_OFS_DN_HI     = 8'h08;
  localparam logic [7:0] SEV_OFS_DN_LO     = 8'h09;
  localparam logic [7:0] SEV_OFS_PERSIST   = 8'h0A;
  localparam logic [7:0] SEV_OFS_NEAR_IND  = 8'h0B;
  localparam logic [7:0] SEV_OFS_NEAR_THR  = 8'h0C;
  localparam logic [7:0] SEV_OFS_GREEN_GN  = 8'h0F;
  localparam logic [7:0] SEV_OFS_IR_GN     = 8'h10;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SEV_RST_STATUS    = 8'h04;
  localparam logic [7:0] SEV_RST_CONTROL   = 8'h24;
  localparam logic [7:0] SEV_RST_THRESH    = 8'h00;
  localparam logic [7:0] SEV_RST_PERSIST   = 8'h00;
  localparam logic [7:0] SEV_RST_GAIN      = 8'h80;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SEV_BIT_LIGHT_FLAG  = 0;
  localparam int SEV_BIT_NEAR_FLAG   = 1;
  localparam int SEV_BIT_POWER_FLAG  = 2;
  localparam int SEV_BIT_LIGHT_EN    = 0;
  localparam int SEV_BIT_NEAR_EN     = 1;
  localparam int SEV_LSB_MODE        = 2;
  localparam int SEV_MSB_MODE        = 4;
  localparam int SEV_BIT_GAIN_SRC    = 5;
  localparam int SEV_LSB_LIGHT_PST   = 0;
  localparam int SEV_LSB_NEAR_PST    = 2;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEV_MODE_SHUTDOWN  = 3'h0;
  localparam logic [2:0] SEV_MODE_G_MINUS_IR = 3'h1;
  localparam logic [2:0] SEV_MODE_GREEN     = 3'h2;
  localparam logic [2:0] SEV_MODE_INFRARED  = 3'h3;
  localparam logic [2:0] SEV_MODE_ALTERNATE = 3'h4;
  localparam logic [2:0] SEV_MODE_NEAR_ONLY = 3'h5;

  typedef enum logic [1:0] {
    SEV_SRC_G_MINUS_IR,
    SEV_SRC_GREEN,
    SEV_SRC_INFRARED,
    SEV_SRC_NONE
  } sev_light_src_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        overflow;
    logic [13:0] value;
  } sev_light_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } sev_near_s;

  typedef struct packed {
    logic [6:0] green;
    logic [8:0] infrared;
  } sev_gain_s;

endpackage : sev_pkg

// [test/sev_regs_chk.sv]
`timescale 1ns/1ps
module sev_chk
  import sev_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_supply_glitch,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic [7:0] o_reg_rdata,
  input  wire sev_light_s i_light,
  input  wire sev_near_s  i_near,
  input  wire sev_gain_s  i_factory_gain,
  input  wire logic       o_event_n_out,
  input  wire logic       o_event_n_oe,
  input  wire sev_gain_s  o_gain,
  input  wire logic       o_analog_on,
  input  wire sev_light_src_e o_light_src,
  input  wire logic       o_light_run,
  input  wire logic       o_near_run
);
  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  logic [7:0] ctl;
  logic [7:0] grn;
  logic [7:0] ir;
  logic [3:0] quiet;
  wire  [2:0] md   = ctl[4:2];
  wire        rd_s = i_reg_rd && i_reg_addr == SEV_OFS_STATUS;
  wire        wr_c = i_reg_wr && i_reg_addr == SEV_OFS_CONTROL;
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctl   <= SEV_RST_CONTROL;
      grn   <= SEV_RST_GAIN;
      ir    <= SEV_RST_GAIN;
      quiet <= 4'hF;
    end else begin
      if (wr_c) ctl <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == SEV_OFS_GREEN_GN) grn <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == SEV_OFS_IR_GN) ir <= i_reg_wdata;
      if (i_supply_glitch) quiet <= 4'h0;
      else if (quiet != 4'hF) quiet <= quiet + 4'h1;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_line_sinks_only: assert property (o_event_n_out == 1'b0)
    else $error("event line drives high");
  chk_read_clears: assert property (rd_s && !i_light.valid &&
    !i_near.valid && quiet > 4'h6 |=> !o_event_n_oe)
    else $error("status read left event asserted");
  chk_flag_holds: assert property (o_event_n_oe && !rd_s && !wr_c
    |=> o_event_n_oe) else $error("event dropped by itself");
  chk_overflow_sets: assert property (i_light.valid &&
    i_light.overflow && ctl[0] && o_light_run && !i_reg_wr
    |=> o_event_n_oe) else $error("overflow missed");
  chk_enable_gate: assert property (rd_s && ctl[1:0] == 2'b00
    |=> o_reg_rdata[1:0] == 2'b00) else $error("disabled flag set");
  chk_shutdown_off: assert property (md == 3'h0 |-> !o_analog_on)
    else $error("analog on in shutdown");
  chk_light_only: assert property (md inside {3'h1, 3'h2, 3'h3}
    |-> o_light_run && !o_near_run) else $error("light mode run bad");
  chk_alternate_run: assert property (md == 3'h4
    |-> o_light_run && o_near_run) else $error("alternate run bad");
  chk_near_only: assert property (md == 3'h5
    |-> !o_light_run && o_near_run) else $error("near only run bad");
  chk_soft_gain: assert property (!ctl[5]
    |-> o_gain == {grn[7:1], ir, grn[0]}) else $error("soft gain bad");
  chk_factory_gain: assert property (ctl[5]
    |-> o_gain == i_factory_gain) else $error("factory gain bad");
  cover property (rd_s && o_event_n_oe);
  cover property (i_near.valid && o_near_run && ctl[1]);
  cover property (wr_c && !i_reg_wdata[1] && o_event_n_oe);
  cover property (rd_s && i_light.valid && i_light.overflow && ctl[0]);
endmodule : sev_chk

// [test/sev_host.sv]
`timescale 1ns/1ps
module sev_host (
  input  wire logic       i_ref_clk,
  input  wire logic       i_event_n_oe,
  input  wire logic [7:0] i_reg_rdata,
  output logic [7:0]      o_reg_addr,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic [7:0]      o_reg_wdata,
  output logic            o_event_level
);
  // Open-drain line: the pull-up wins whenever nobody sinks it.
  assign o_event_level = i_event_n_oe ? 1'b0 : 1'b1;
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_wdata = 8'h00;
  end
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    o_reg_addr  <= a;
    o_reg_wdata <= v;
    o_reg_wr    <= 1'b1;
    @(posedge i_ref_clk);
    o_reg_wr    <= 1'b0;
    o_reg_wdata <= ~v;
    #1;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_ref_clk);
    o_reg_addr <= a;
    o_reg_rd   <= 1'b1;
    @(posedge i_ref_clk);
    o_reg_rd   <= 1'b0;
    #1;
    v = i_reg_rdata;
  endtask : rd
endmodule : sev_host

// [test/tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_top;
  import sev_pkg::*;
  logic clk = 1'b0, rst = 1'b1, glt = 1'b0, wr, rd, eon, eoe, aon;
  logic lrun, nrun, lvl, f, eoe1;
  logic [7:0] adr, wd, rdt, d, v, g1, g2;
  sev_light_s light = '0;
  sev_near_s  near  = '0;
  sev_gain_s  fg    = '0, gain;
  sev_light_src_e src;
  int failures = 0, compares = 0, seed = 3, cyc = 0, cnt, i;
  logic [7:0] ra [10] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B,
                          8'h0C, 8'h0F, 8'h10, 8'h20};
  logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                          8'h00, 8'h80, 8'h80, 8'h00};
  always #25 clk = ~clk;
  sev_regs sev_regs_inst (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_supply_glitch(glt), .i_reg_addr(adr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wd), .o_reg_rdata(rdt), .i_light(light), .i_near(near),
    .i_factory_gain(fg), .o_event_n_out(eon), .o_event_n_oe(eoe),
    .o_gain(gain), .o_analog_on(aon), .o_light_src(src),
    .o_light_run(lrun), .o_near_run(nrun));
  // A first-revision copy on the same bus shows the power flag kept off the
  // event line.
  sev_regs #(.FIRST_REVISION(1'b1)) sev_regs_rev1_inst (.i_ref_clk(clk),
    .i_sys_rst(rst), .i_supply_glitch(glt), .i_reg_addr(adr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(), .i_light(light),
    .i_near(near), .i_factory_gain(fg), .o_event_n_out(),
    .o_event_n_oe(eoe1), .o_gain(), .o_analog_on(), .o_light_src(),
    .o_light_run(), .o_near_run());
  sev_host host_inst (.i_ref_clk(clk), .i_event_n_oe(eoe), .i_reg_rdata(rdt),
    .o_reg_addr(adr), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wd),
    .o_event_level(lvl));
  task report_and_stop;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop;
    end
  end
  task rchk(input logic [7:0] a, input logic [7:0] e);
    host_inst.rd(a, d);
    `CHK(d, e)
  endtask : rchk
  task lsamp(input logic o, input logic [13:0] x);
    @(posedge clk) light <= {1'b1, o, x};
    @(posedge clk) light.valid <= 1'b0;
    #1;
  endtask : lsamp
  task nsamp(input logic [7:0] x);
    @(posedge clk) near <= {1'b1, x};
    @(posedge clk) near.valid <= 1'b0;
    #1;
  endtask : nsamp
  function automatic sev_light_src_e xsrc(input int m);
    case (m)
      1, 4: return SEV_SRC_G_MINUS_IR;
      2: return SEV_SRC_GREEN;
      3: return SEV_SRC_INFRARED;
      default: return SEV_SRC_NONE;
    endcase
  endfunction : xsrc
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    `CHK(eoe, 1'b1)
    `CHK(eoe1, 1'b0)
    rchk(8'h00, 8'h04);
    `CHK(lvl, 1'b1)
    rchk(8'h01, 8'h24);
    for (i = 0; i < 10; i++) rchk(ra[i], rv[i]);
    lsamp(1'b1, 14'h0);
    `CHK(eoe, 1'b0)
    host_inst.wr(8'h01, 8'h05);
    lsamp(1'b1, 14'h0);
    `CHK(eoe, 1'b1)
    rchk(8'h00, 8'h01);
    `CHK(eoe, 1'b0)
    // An overflow taken at the clearing read's edge must survive the read.
    fork
      host_inst.rd(8'h00, d);
      lsamp(1'b1, 14'h0);
    join
    `CHK(d, 8'h00)
    `CHK(eoe, 1'b1)
    rchk(8'h00, 8'h01);
    `CHK(eoe, 1'b0)
    for (i = 0; i < 5; i++) host_inst.wr(ra[i], (i == 0) ? 8'h01 :
      (i == 3) ? 8'h10 : (i == 4) ? 8'h05 : 8'h00);
    lsamp(1'b0, 14'h200);
    `CHK(eoe, 1'b0)
    lsamp(1'b0, 14'h80);
    lsamp(1'b0, 14'h5);
    `CHK(eoe, 1'b0)
    lsamp(1'b0, 14'h3);
    `CHK(eoe, 1'b1)
    host_inst.wr(8'h01, 8'h04);
    `CHK(eoe, 1'b0)
    host_inst.wr(8'h01, 8'h00);
    rchk(8'h06, 8'h01);
    for (i = 0; i < 6; i++) begin
      host_inst.wr(8'h01, {3'b000, 3'(i), 2'b11});
      `CHK(src, xsrc(i))
      `CHK(aon, i != 0)
      `CHK(lrun, i >= 1 && i <= 4)
      `CHK(nrun, i >= 4)
      repeat (3) nsamp(8'hFF);
      `CHK(eoe, i >= 4)
      host_inst.rd(8'h00, d);
      nsamp(8'h00);
    end
    host_inst.wr(8'h0C, 8'h80);
    host_inst.wr(8'h01, 8'h17);
    cnt = 0;
    f = 1'b0;
    for (i = 0; i < 60; i++) begin
      lsamp(1'b1, 14'($random(seed)));
      v = 8'($random(seed));
      nsamp(v);
      cnt = (v > 8'h80) ? cnt + 1 : 0;
      f = f | (cnt > 1);
      `CHK(eoe, f)
      if (f) begin
        rchk(8'h00, 8'h02);
        nsamp(8'h00);
        cnt = 0;
        f = 1'b0;
      end
    end
    repeat (2) nsamp(8'hFF);
    host_inst.wr(8'h01, 8'h15);
    `CHK(eoe, 1'b0)
    for (i = 0; i < 2; i++) begin
      g1 = 8'($random(seed));
      g2 = 8'($random(seed));
      host_inst.wr(8'h0F, g1);
      host_inst.wr(8'h10, g2);
      @(posedge clk) fg <= 16'($random(seed));
      host_inst.wr(8'h01, (i == 1) ? 8'h20 : 8'h00);
      `CHK(gain, (i == 1) ? fg : {g1[7:1], g2, g1[0]})
    end
    @(posedge clk) glt <= 1'b1;
    repeat (4) @(posedge clk);
    glt <= 1'b0;
    host_inst.wr(8'h01, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    `CHK(eoe, 1'b1)
    `CHK(eoe1, 1'b0)
    rchk(8'h00, 8'h04);
    rchk(8'h0A, 8'h00);
    rchk(8'h00, 8'h00);
    report_and_stop;
  end
endmodule : tb_top
bind sev_regs sev_chk sev_chk_inst (.i_ref_clk, .i_sys_rst, .i_supply_glitch,
  .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_light,
  .i_near, .i_factory_gain, .o_event_n_out, .o_event_n_oe, .o_gain,
  .o_analog_on, .o_light_src, .o_light_run, .o_near_run);
